/* File: src/tmr_evt_ctrl.sv */
// Top of the timer event, interrupt and DMA trigger control block.
// How it works
// R1 - Nine enabled events each start DMA sequence; the RTC event starts one only in RTC configuration.
// R2 - DMA trigger enable mask readable as word.
// R3 - Nine interrupt sources, each individually enabled.
// R4 - Only enabled sources drive processor interrupt.
// R5 - Clear mask deasserts selected sources until re-event.
// R6 - Raw and masked status share bit layout.
// R7 - Enables start and stop half A, B, both.
// R8 - Software configures a half before enabling it.
// R9 - Load write while counting goes in immediately.
// R10 - Last programmed load value reads back.
// R11 - Full-width uses half A load only.
// R12 - One-shot, periodic, RTC and split configurations.
// R13 - Event in clear cycle keeps source set.
`timescale 1ns/1ps
module tmr_evt_ctrl import tmr_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire tmr_cfg_t i_cfg,
  input wire logic i_periodic_b,
  input wire tmr_sel_t i_en_wr,
  input wire tmr_sel_t i_en_val,
  input wire tmr_load_wr_t i_load_wr,
  input wire logic i_load_rd_sel_b,
  input wire logic i_dma_mask_wr,
  input wire logic [8:0] i_dma_mask_val,
  input wire logic i_irq_en_wr,
  input wire logic [8:0] i_irq_en_val,
  input wire logic i_irq_clr_wr,
  input wire logic [8:0] i_irq_clr_val,
  input wire logic [8:0] i_evt,
  input wire logic i_rtc_evt,
  input wire logic i_dma_done_a,
  input wire logic i_dma_done_b,
  output logic [8:0] o_dma_mask,
  output logic [8:0] o_dma_start,
  output logic [8:0] o_irq_raw,
  output logic [8:0] o_irq_masked,
  output logic [8:0] o_irq_en,
  output logic o_irq,
  output logic [31:0] o_load_rd,
  output tmr_sel_t o_running
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode and half control.

  logic split;
  logic periodic_a;
  tmr_sel_t en_q;
  tmr_sel_t en_d;
  logic [CNT_W-1:0] load_a;
  logic [CNT_W-1:0] load_b;
  logic [CNT_W-1:0] cnt_a;
  logic [CNT_W-1:0] cnt_b;
  logic tmo_a;
  logic tmo_b;
  logic wr_a;
  logic wr_b;
  logic [CNT_W-1:0] wval_b;

  // RTC mode runs half A as a free periodic counter; full width never runs half B.
  assign split = (i_cfg == TMR_CFG_SPLIT); // [R12]
  assign periodic_a = (i_cfg == TMR_CFG_PERIODIC) || (i_cfg == TMR_CFG_RTC) || split; // [R12]
  assign en_d.half_a = i_en_wr.half_a ? i_en_val.half_a : en_q.half_a; // [R7]
  assign en_d.half_b = (i_en_wr.half_b ? i_en_val.half_b : en_q.half_b) && split; // [R7] [R11]
  assign wr_a = i_load_wr.wr && i_load_wr.sel.half_a;
  // Half B ignores load writes in full-width operation, so its field stays unused.
  assign wr_b = i_load_wr.wr && i_load_wr.sel.half_b && split; // [R11]
  assign wval_b = {{(CNT_W-HALF_W){1'b0}}, i_load_wr.value[HALF_W-1:0]};

  // Enables are plain software state; software sets up the mode beforehand.
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      en_q <= '0;
    end else begin
      en_q <= en_d; // [R8]
    end
  end

  tmr_half #(.W(CNT_W)) u_half_a (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_en(en_q.half_a),
    .i_periodic(periodic_a),
    .i_load_wr(wr_a),
    .i_load_val(i_load_wr.value),
    .o_load(load_a),
    .o_count(cnt_a),
    .o_timeout(tmo_a)
  );

  tmr_half #(.W(CNT_W)) u_half_b (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_en(en_q.half_b),
    .i_periodic(i_periodic_b),
    .i_load_wr(wr_b),
    .i_load_val(wval_b),
    .o_load(load_b),
    .o_count(cnt_b),
    .o_timeout(tmo_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event collection.

  logic [8:0] dma_evt;
  logic [8:0] irq_evt;

  // External capture and match events join the internal timeouts.
  assign dma_evt = {i_evt[DMA_MODEMATCH_B], i_evt[DMA_CAPEVENT_B], i_evt[DMA_CAPMATCH_B], tmo_b,
                    i_evt[DMA_MODEMATCH_A], i_rtc_evt && (i_cfg == TMR_CFG_RTC),
                    i_evt[DMA_CAPEVENT_A], i_evt[DMA_CAPMATCH_A], tmo_a};
  assign irq_evt = {i_dma_done_b, i_evt[DMA_CAPEVENT_B], i_evt[DMA_CAPMATCH_B], tmo_b,
                    i_dma_done_a, i_rtc_evt, i_evt[DMA_CAPEVENT_A], i_evt[DMA_CAPMATCH_A], tmo_a};

  ////////////////////////////////////////////////////////////////////////////
  // DMA trigger mask and start pulses.

  logic [8:0] dma_mask_q;
  logic [8:0] dma_start_q;
  logic [8:0] dma_start_d;

  assign dma_start_d = dma_evt & dma_mask_q; // [R1]

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      dma_mask_q <= RST_MASK;
      dma_start_q <= '0;
    end else begin
      if (i_dma_mask_wr) begin
        dma_mask_q <= i_dma_mask_val; // [R2]
      end
      dma_start_q <= dma_start_d; // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and output.

  logic [8:0] raw_q;
  logic [8:0] raw_d;
  logic [8:0] irq_en_q;
  logic [8:0] masked_d;
  logic [8:0] clr;

  assign clr = i_irq_clr_wr ? i_irq_clr_val : 9'h000;
  // The new event wins over a clear in the same cycle so it is never dropped.
  assign raw_d = (raw_q & ~clr) | irq_evt; // [R5] [R13]
  assign masked_d = raw_d & (i_irq_en_wr ? i_irq_en_val : irq_en_q); // [R4] [R6]

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      raw_q <= '0;
      irq_en_q <= RST_MASK;
      o_irq_masked <= '0;
      o_irq <= 1'b0;
    end else begin
      raw_q <= raw_d; // [R3]
      if (i_irq_en_wr) begin
        irq_en_q <= i_irq_en_val; // [R3]
      end
      o_irq_masked <= masked_d; // [R6]
      o_irq <= |masked_d; // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback registers.

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_load_rd <= RST_LOAD;
    end else begin
      o_load_rd <= (i_load_rd_sel_b && split) ? load_b : load_a; // [R10]
    end
  end

  assign o_dma_mask = dma_mask_q;
  assign o_dma_start = dma_start_q;
  assign o_irq_raw = raw_q;
  assign o_irq_en = irq_en_q;
  assign o_running = en_q;

  // A load into half A followed by a quiet cycle with half A selected for readback.
  sequence s_load_a_then_rd;
    wr_a ##1 !wr_a && !i_load_rd_sel_b;
  endsequence

  chk_irq_gated: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R4]
    o_irq == |(o_irq_raw & o_irq_en))
    else $error("interrupt raised by a disabled source");
  chk_clear_wins: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R5]
    i_irq_clr_wr && i_irq_clr_val[0] && !irq_evt[0] |=> !raw_q[0])
    else $error("cleared source still set");
  chk_set_beats_clr: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R13]
    i_irq_clr_wr && i_irq_clr_val[1] && irq_evt[1] |=> raw_q[1])
    else $error("event lost in clear cycle");
  chk_dma_start: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R1]
    o_dma_start == $past(dma_evt & dma_mask_q))
    else $error("dma start does not follow enabled events");
  chk_dma_mask_rd: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R2]
    i_dma_mask_wr |=> o_dma_mask == $past(i_dma_mask_val))
    else $error("dma mask readback wrong");
  chk_masked_view: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R6]
    o_irq_masked == (o_irq_raw & o_irq_en))
    else $error("masked view disagrees with raw view");
  chk_half_b_full: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R7]
    !split |=> !en_q.half_b)
    else $error("half b running in full width");
  chk_load_rd: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R10]
    s_load_a_then_rd |=> o_load_rd == $past(i_load_wr.value, 2))
    else $error("load readback wrong");

  // Stopped halves hold their count; this also keeps the counter outputs of both halves watched.
  chk_a_frozen: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R7]
    !en_q.half_a && !wr_a |=> $stable(cnt_a))
    else $error("stopped half a changed its count");
  chk_b_frozen: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R7]
    !en_q.half_b && !wr_b |=> $stable(cnt_b))
    else $error("stopped half b changed its count");
  // The calendar trigger is refused outside the calendar configuration.
  chk_rtc_dma_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R1]
    i_cfg != TMR_CFG_RTC |=> !o_dma_start[DMA_RTC_A])
    else $error("calendar trigger outside calendar configuration");

endmodule

/* File: src/tmr_pkg.sv */
// Package with constants and carrier types for the timer event and interrupt control block.
package tmr_pkg;

  // Bit positions of the nine DMA trigger sources.
  localparam int DMA_TIMEOUT_A = 0;
  localparam int DMA_CAPMATCH_A = 1;
  localparam int DMA_CAPEVENT_A = 2;
  localparam int DMA_RTC_A = 3;
  localparam int DMA_MODEMATCH_A = 4;
  localparam int DMA_TIMEOUT_B = 5;
  localparam int DMA_CAPMATCH_B = 6;
  localparam int DMA_CAPEVENT_B = 7;
  localparam int DMA_MODEMATCH_B = 8;
  localparam int NUM_SRC = 9;

  // Bit positions of the nine interrupt sources.
  localparam int IRQ_TIMEOUT_A = 0;
  localparam int IRQ_CAPMATCH_A = 1;
  localparam int IRQ_CAPEVENT_A = 2;
  localparam int IRQ_RTC_MATCH = 3;
  localparam int IRQ_DMA_DONE_A = 4;
  localparam int IRQ_TIMEOUT_B = 5;
  localparam int IRQ_CAPMATCH_B = 6;
  localparam int IRQ_CAPEVENT_B = 7;
  localparam int IRQ_DMA_DONE_B = 8;

  // Values after reset and counter widths.
  localparam logic [8:0] RST_MASK = 9'h000;
  localparam logic [31:0] RST_LOAD = 32'h0000_0000;
  localparam int CNT_W = 32;
  localparam int HALF_W = 16;

  // Timer configuration codes.
  typedef enum logic [2:0] {
    TMR_CFG_ONE_SHOT = 3'h0,
    TMR_CFG_PERIODIC = 3'h1,
    TMR_CFG_RTC = 3'h3,
    TMR_CFG_SPLIT = 3'h2
  } tmr_cfg_t;

  // Half select for load accesses.
  typedef struct packed {
    logic half_b;
    logic half_a;
  } tmr_sel_t;

  // A load write request.
  typedef struct packed {
    logic wr;
    tmr_sel_t sel;
    logic [CNT_W-1:0] value;
  } tmr_load_wr_t;

endpackage

/* File: src/tmr_half.sv */
// One timer half: counter with immediate load transfer and timeout event.
`timescale 1ns/1ps
module tmr_half import tmr_pkg::*; #(
  parameter int W = CNT_W
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_en,
  input wire logic i_periodic,
  input wire logic i_load_wr,
  input wire logic [W-1:0] i_load_val,
  output logic [W-1:0] o_load,
  output logic [W-1:0] o_count,
  output logic o_timeout
);

  logic [W-1:0] load_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tmo_q;
  logic at_zero;
  logic running;

  // A one-shot half stops after its timeout until it is enabled again.
  logic done_q;
  assign at_zero = (cnt_q == '0);
  assign running = i_en && !done_q;

  // A new load goes straight into the counter so a long interval never delays the change.
  assign cnt_d = i_load_wr ? i_load_val :
                 !running ? cnt_q :
                 at_zero ? load_q :
                 cnt_q - W'(1);

  // Counter, reload register and timeout pulse.
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      load_q <= '0;
      cnt_q <= '0;
      tmo_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (i_load_wr) begin
        load_q <= i_load_val; // [R10]
      end
      cnt_q <= cnt_d; // [R9] [R7]
      tmo_q <= running && at_zero && !i_load_wr;
      if (!i_en) begin
        done_q <= 1'b0;
      end else if (running && at_zero && !i_load_wr && !i_periodic) begin
        done_q <= 1'b1;
      end
    end
  end

  assign o_load = load_q;
  assign o_count = cnt_q;
  assign o_timeout = tmo_q;

  chk_load_immediate: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R9]
    i_load_wr |=> (cnt_q == $past(i_load_val)) && (load_q == $past(i_load_val)))
    else $error("load value not transferred at once");
  chk_stopped_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [R7]
    !i_en && !i_load_wr |=> $stable(cnt_q))
    else $error("disabled half kept counting");

endmodule

/* File: dv/tmr_dma_model.sv */
// Behavioural model of the DMA controller that answers trigger pulses with completion pulses.
`timescale 1ns/1ps
module tmr_dma_model #(
  parameter int DELAY = 3
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [8:0] i_start,
  output logic o_done_a,
  output logic o_done_b
);
  logic [DELAY-1:0] pend_a_q;
  logic [DELAY-1:0] pend_b_q;
  // A shift line per half stands in for the transfer time, so completion never comes in the trigger cycle.
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      pend_a_q <= '0;
      pend_b_q <= '0;
    end else begin
      pend_a_q <= {pend_a_q[DELAY-2:0], |i_start[4:0]};
      pend_b_q <= {pend_b_q[DELAY-2:0], |i_start[8:5]};
    end
  end
  // The completion is a one-cycle pulse per half for each cycle in which any trigger of that half fired.
  assign o_done_a = pend_a_q[DELAY-1];
  assign o_done_b = pend_b_q[DELAY-1];
endmodule

/* File: dv/timer_event_irq_dma_control_test.sv */
// Self-checking testbench for the timer event, interrupt and DMA trigger control block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module timer_event_irq_dma_control_test import tmr_pkg::*;;
  logic i_mclk, i_nrst, i_periodic_b, i_load_rd_sel_b, i_dma_mask_wr, i_irq_en_wr, i_irq_clr_wr, i_rtc_evt;
  logic i_dma_done_a, i_dma_done_b, o_irq;
  tmr_cfg_t i_cfg;
  tmr_sel_t i_en_wr, i_en_val, o_running;
  tmr_load_wr_t i_load_wr;
  logic [8:0] i_dma_mask_val, i_irq_en_val, i_irq_clr_val, i_evt;
  logic [8:0] o_dma_mask, o_dma_start, o_irq_raw, o_irq_masked, o_irq_en;
  logic [31:0] o_load_rd;
  int mismatches = 0;
  int n_tests = 0;
  int k;
  tmr_evt_ctrl dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cfg(i_cfg), .i_periodic_b(i_periodic_b),
    .i_en_wr(i_en_wr), .i_en_val(i_en_val), .i_load_wr(i_load_wr), .i_load_rd_sel_b(i_load_rd_sel_b),
    .i_dma_mask_wr(i_dma_mask_wr), .i_dma_mask_val(i_dma_mask_val), .i_irq_en_wr(i_irq_en_wr),
    .i_irq_en_val(i_irq_en_val), .i_irq_clr_wr(i_irq_clr_wr), .i_irq_clr_val(i_irq_clr_val), .i_evt(i_evt),
    .i_rtc_evt(i_rtc_evt), .i_dma_done_a(i_dma_done_a), .i_dma_done_b(i_dma_done_b), .o_dma_mask(o_dma_mask),
    .o_dma_start(o_dma_start), .o_irq_raw(o_irq_raw), .o_irq_masked(o_irq_masked), .o_irq_en(o_irq_en),
    .o_irq(o_irq), .o_load_rd(o_load_rd), .o_running(o_running));
  // The DMA partner answers every trigger after a few cycles.
  tmr_dma_model #(.DELAY(3)) dma_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_start(o_dma_start),
    .o_done_a(i_dma_done_a), .o_done_b(i_dma_done_b));
  // Free-running 50 MHz clock.
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Strobe tasks drive at one edge and release at the sampling edge, then settle.
  task automatic irq_en(input logic [8:0] v);
    @(posedge i_mclk);
    i_irq_en_wr <= 1'b1;
    i_irq_en_val <= v;
    @(posedge i_mclk);
    i_irq_en_wr <= 1'b0;
    #1;
  endtask
  task automatic clr_evt(input logic [8:0] c, input logic [8:0] e);
    @(posedge i_mclk);
    i_irq_clr_wr <= |c;
    i_irq_clr_val <= c;
    i_evt <= e;
    @(posedge i_mclk);
    i_irq_clr_wr <= 1'b0;
    i_evt <= 9'h000;
    #1;
  endtask
  task automatic dmask(input logic [8:0] v);
    @(posedge i_mclk);
    i_dma_mask_wr <= 1'b1;
    i_dma_mask_val <= v;
    @(posedge i_mclk);
    i_dma_mask_wr <= 1'b0;
    #1;
  endtask
  task automatic en(input logic [1:0] w, input logic [1:0] v);
    @(posedge i_mclk);
    i_en_wr <= w;
    i_en_val <= v;
    @(posedge i_mclk);
    i_en_wr <= 2'b00;
    #1;
  endtask
  task automatic load(input logic [1:0] s, input logic [31:0] v);
    @(posedge i_mclk);
    i_load_wr <= {1'b1, s, v};
    @(posedge i_mclk);
    i_load_wr.wr <= 1'b0;
    @(posedge i_mclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Enabled triggers start the partner; only masked events pass, for one cycle.
  task automatic t_dma();
    dmask(9'h116);
    `CHK(o_dma_mask, 9'h116)
    clr_evt(9'h000, 9'h1d6);
    `CHK(o_dma_start, 9'h116)
    `CHK(o_irq_raw, 9'h0c6)
    @(posedge i_mclk);
    #1;
    `CHK(o_dma_start, 9'h000)
    repeat (4) @(posedge i_mclk);
    #1;
    `CHK(o_irq_raw, 9'h1d6)
    clr_evt(9'h1ff, 9'h000);
    `CHK(o_irq_raw, 9'h000)
  endtask
  // Disabled sources show raw only; clear drops a source unless a new event coincides.
  task automatic t_irq();
    dmask(9'h000); // No DMA completion may land among these checks.
    irq_en(9'h002);
    `CHK(o_irq_en, 9'h002)
    clr_evt(9'h000, 9'h040);
    `CHK({o_irq_raw, o_irq_masked, o_irq}, {9'h040, 9'h000, 1'b0})
    clr_evt(9'h000, 9'h002);
    `CHK({o_irq_raw, o_irq_masked, o_irq}, {9'h042, 9'h002, 1'b1})
    clr_evt(9'h002, 9'h000);
    `CHK({o_irq_raw, o_irq}, {9'h040, 1'b0})
    clr_evt(9'h002, 9'h002);
    `CHK({o_irq_raw, o_irq}, {9'h042, 1'b1})
    irq_en(9'h042);
    `CHK(o_irq_masked, 9'h042)
    clr_evt(9'h1ff, 9'h000);
    `CHK({o_irq_raw, o_irq}, {9'h000, 1'b0})
  endtask
  // Halves start and stop separately; half B is refused in full-width mode.
  task automatic t_run();
    i_cfg <= TMR_CFG_SPLIT;
    en(2'b11, 2'b11);
    `CHK(o_running, 2'b11)
    en(2'b01, 2'b00);
    `CHK(o_running, 2'b10)
    en(2'b11, 2'b00);
    i_cfg <= TMR_CFG_ONE_SHOT;
    en(2'b11, 2'b11);
    `CHK(o_running, 2'b01)
    en(2'b11, 2'b00);
  endtask
  // A reload while counting takes effect at once, so a timeout follows quickly.
  task automatic t_load();
    i_cfg <= TMR_CFG_PERIODIC;
    load(2'b01, 32'h0001_0000);
    en(2'b01, 2'b01);
    clr_evt(9'h1ff, 9'h000);
    load(2'b01, 32'h0000_0004);
    `CHK(o_load_rd, 32'h0000_0004)
    k = 0;
    while (o_irq_raw[IRQ_TIMEOUT_A] !== 1'b1 && k < 12) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    `CHK(k < 12, 1'b1)
    en(2'b01, 2'b00);
    i_cfg <= TMR_CFG_SPLIT;
    load(2'b10, 32'habcd_1234);
    i_load_rd_sel_b <= 1'b1;
    @(posedge i_mclk);
    #1;
    `CHK(o_load_rd, 32'h0000_1234)
    i_load_rd_sel_b <= 1'b0;
    clr_evt(9'h1ff, 9'h000);
  endtask
  // The clock-match trigger and interrupt work in the calendar configuration.
  task automatic t_rtc();
    i_cfg <= TMR_CFG_RTC;
    dmask(9'h008);
    @(posedge i_mclk);
    i_rtc_evt <= 1'b1;
    @(posedge i_mclk);
    i_rtc_evt <= 1'b0;
    #1;
    `CHK(o_dma_start, 9'h008)
    `CHK(o_irq_raw[IRQ_RTC_MATCH], 1'b1)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence: reset for three cycles, then every scenario in turn.
  initial begin
    {i_nrst, i_periodic_b, i_load_rd_sel_b, i_dma_mask_wr, i_irq_en_wr, i_irq_clr_wr, i_rtc_evt} = 7'h00;
    {i_en_wr, i_en_val, i_load_wr, i_dma_mask_val, i_irq_en_val, i_irq_clr_val, i_evt} = '0;
    i_cfg = TMR_CFG_ONE_SHOT;
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    #1;
    `CHK({o_irq_raw, o_irq, o_dma_mask, o_running, o_load_rd}, 53'h0)
    t_dma();
    t_irq();
    t_run();
    t_load();
    t_rtc();
    give_verdict();
  end
  // Watchdog well beyond the few dozen cycles the scenarios need.
  initial begin
    repeat (5000) @(posedge i_mclk);
    mismatches++;
    give_verdict();
  end
endmodule
